// ===== hdl/spq_pkg.sv
`default_nettype none
// ****************************************
// Shared types
// ****************************************
package spq_pkg;
    // Master shifter states
    typedef enum logic {
        SPQ_IDLE,
        SPQ_SHIFT
    } spq_state_t;
endpackage : spq_pkg
`default_nettype wire

// ===== hdl/spq_regs.svh
`ifndef SPQ_REGS_SVH
`define SPQ_REGS_SVH
// ****************************************
// Timing and width constants
// ****************************************
// Bits in one exchange
`define SPQ_BITS_PER_BYTE 4'h8
// Last bit index of a byte
`define SPQ_LAST_BIT 3'h7
// Master half-period of the serial clock minus one, in sys_clk cycles, per rate select
// Fastest rate leaves room for the clock-out flop plus the two-flop input sync
`define SPQ_HALF_RATE0 8'h03
`define SPQ_HALF_RATE1 8'h04
`define SPQ_HALF_RATE2 8'h10
`define SPQ_HALF_RATE3 8'h40
// Reset values
`define SPQ_BYTE_ZERO 8'h00
`define SPQ_CNT_ZERO 3'h0
`define SPQ_DIV_ZERO 8'h00
`define SPQ_RATE_ZERO 2'h0
`endif

// ===== hdl/spq_spi_core.sv
`include "spq_regs.svh"
`default_nettype none
module spq_spi_core (
    // Clocks and reset
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic linkClk,
    // Control write strobe and fields
    input wire logic ctlWrite,
    input wire logic enableIn,
    input wire logic masterIn,
    input wire logic wiredOrIn,
    input wire logic txIrqEnIn,
    input wire logic rxIrqEnIn,
    input wire logic errIrqEnIn,
    input wire logic faultDetEnIn,
    input wire logic [1:0] rateIn,
    // CPU data and status accesses
    input wire logic dataWrite,
    input wire logic [7:0] dataIn,
    input wire logic dataRead,
    input wire logic statusRead,
    // System states
    input wire logic waitMode,
    input wire logic stopMode,
    input wire logic breakActive,
    input wire logic breakClearEnable,
    // Serial pins
    input wire logic mosiIn,
    input wire logic misoIn,
    input wire logic slaveSelN,
    output logic sckOut,
    output logic sckOe,
    output logic mosiOut,
    output logic mosiOe,
    output logic misoOut,
    output logic misoOe,
    output logic pinsOwned,
    // Status and data to CPU
    output logic [7:0] rxData,
    output logic txEmptyFlag,
    output logic rxFullFlag,
    output logic overflowFlag,
    output logic modeFaultFlag,
    output logic enableFlag,
    // Interrupt requests
    output logic txIrq,
    output logic rxIrq
);
    // ****************************************
    // Control register bits
    // ****************************************
    logic enable_q, master_q, wiredOr_q, txIe_q, rxIe_q, error_irq_enable_q, faultEn_q;
    logic [1:0] rate_q;
    // Flags and buffers
    logic txEmpty_q, rxFull_q, ovf_q, mode_fault_flag_q;
    logic [7:0] txBuf_q, rxData_q;
    // Two-step clear arming
    logic ovfArm_q, modfArm_q;
    // Master shifter
    spq_pkg::spq_state_t state_q;
    logic [7:0] mShift_q, div_q;
    logic [2:0] mCnt_q;
    logic sck_q, sample_q, mosi_q;
    // Pin synchronisers
    logic misoS1_q, misoS2_q, ssS1_q, ssS2_q;
    // Crossing toggles
    logic txTgl_q, ackS1_q, ackS2_q, ackSeen_q;
    logic doneS1_q, doneS2_q, doneSeen_q;
    logic slvRst_q;
    // Slave domain
    logic rstL1_q, rstL2_q, ldL1_q, ldL2_q, ldSeen_q;
    logic ackTgl_q, doneTgl_q, miso_q;
    logic [7:0] sShift_q, sHold_q;
    logic [2:0] sCnt_q;
    logic [7:0] sNext;
    // Derived terms
    logic accessOk, flagOk, mDone, sDone, slvAck, rxEvt;
    logic [7:0] mByte, rxByte, halfCnt;
    logic edgeHit, faultNow;

    // Half-period decode from rate select
    function automatic logic [7:0] halfOf(input logic [1:0] r);
        if (r == 2'h0) begin
            halfOf = `SPQ_HALF_RATE0;
        end else if (r == 2'h1) begin
            halfOf = `SPQ_HALF_RATE1;
        end else if (r == 2'h2) begin
            halfOf = `SPQ_HALF_RATE2;
        end else begin
            halfOf = `SPQ_HALF_RATE3;
        end
    endfunction : halfOf

    // ****************************************
    // Combinational helpers
    // ****************************************
    // Accesses blocked in wait mode
    assign accessOk = !waitMode;
    // Flag changes from accesses frozen in break unless clear enable is set
    assign flagOk = accessOk && (!breakActive || breakClearEnable);
    assign halfCnt = halfOf(rate_q);
    assign edgeHit = (state_q == spq_pkg::SPQ_SHIFT) && (div_q == halfCnt);
    // Last falling edge ends the master byte
    assign mDone = edgeHit && sck_q && (mCnt_q == `SPQ_LAST_BIT);
    assign mByte = {mShift_q[6:0], sample_q};
    assign sDone = doneS2_q ^ doneSeen_q;
    assign slvAck = ackS2_q ^ ackSeen_q;
    assign rxEvt = master_q ? mDone : sDone;
    assign rxByte = master_q ? mByte : sHold_q;
    // Master sees select low with detection on
    assign faultNow = enable_q && master_q && faultEn_q && !ssS2_q;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Two flops before any sys_clk logic reads the pins
    always_ff @(posedge sys_clk) begin
        misoS1_q <= misoIn;
        misoS2_q <= misoS1_q;
        ssS1_q <= slaveSelN;
        ssS2_q <= ssS1_q;
        ackS1_q <= ackTgl_q;
        ackS2_q <= ackS1_q;
        doneS1_q <= doneTgl_q;
        doneS2_q <= doneS1_q;
    end

    // ****************************************
    // Control bits
    // ****************************************
    // Only system reset loads defaults (master set, the rest cleared); mode fault drops enable
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            enable_q <= 1'b0;
            master_q <= 1'b1;
            wiredOr_q <= 1'b0;
            txIe_q <= 1'b0;
            rxIe_q <= 1'b0;
            error_irq_enable_q <= 1'b0;
            faultEn_q <= 1'b0;
            rate_q <= `SPQ_RATE_ZERO;
        end else if (!stopMode) begin
            if (faultNow) begin
                enable_q <= 1'b0;
            end else if (ctlWrite && accessOk) begin
                enable_q <= enableIn;
            end
            if (ctlWrite && accessOk) begin
                master_q <= masterIn;
                wiredOr_q <= wiredOrIn;
                txIe_q <= txIrqEnIn;
                rxIe_q <= rxIrqEnIn;
                error_irq_enable_q <= errIrqEnIn;
                faultEn_q <= faultDetEnIn;
                rate_q <= rateIn;
            end
        end
    end

    // ****************************************
    // Transmit buffer
    // ****************************************
    // Write only counts while empty; ignored in protected break
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            txEmpty_q <= 1'b1;
            txBuf_q <= `SPQ_BYTE_ZERO;
            txTgl_q <= 1'b0;
            ackSeen_q <= 1'b0;
        end else if (!stopMode) begin
            ackSeen_q <= ackS2_q;
            if (!enable_q) begin
                txEmpty_q <= 1'b1;
            end else if (dataWrite && flagOk && txEmpty_q) begin
                txBuf_q <= dataIn;
                txEmpty_q <= 1'b0;
                txTgl_q <= ~txTgl_q;
            end else if (!txEmpty_q && master_q && (state_q == spq_pkg::SPQ_IDLE || mDone)) begin
                txEmpty_q <= 1'b1;
            end else if (!txEmpty_q && !master_q && slvAck) begin
                txEmpty_q <= 1'b1;
            end
        end
    end

    // ****************************************
    // Master shifter
    // ****************************************
    // Shift out on falling edge, sample on rising edge
    always_ff @(posedge sys_clk) begin
        if (reset || !enable_q || !master_q) begin
            state_q <= spq_pkg::SPQ_IDLE;
            mShift_q <= `SPQ_BYTE_ZERO;
            mCnt_q <= `SPQ_CNT_ZERO;
            div_q <= `SPQ_DIV_ZERO;
            sck_q <= 1'b0;
            sample_q <= 1'b0;
            mosi_q <= 1'b1;
        end else if (!stopMode) begin
            case (state_q)
                spq_pkg::SPQ_IDLE: begin
                    if (!txEmpty_q) begin
                        state_q <= spq_pkg::SPQ_SHIFT;
                        mShift_q <= txBuf_q;
                        mosi_q <= txBuf_q[7];
                        mCnt_q <= `SPQ_CNT_ZERO;
                        div_q <= `SPQ_DIV_ZERO;
                    end
                end
                spq_pkg::SPQ_SHIFT: begin
                    if (!edgeHit) begin
                        div_q <= div_q + 8'h01;
                    end else begin
                        div_q <= `SPQ_DIV_ZERO;
                        sck_q <= ~sck_q;
                        if (!sck_q) begin
                            sample_q <= misoS2_q;
                        end else if (mDone && !txEmpty_q) begin
                            mShift_q <= txBuf_q;
                            mosi_q <= txBuf_q[7];
                            mCnt_q <= `SPQ_CNT_ZERO;
                        end else if (mDone) begin
                            mShift_q <= mByte;
                            state_q <= spq_pkg::SPQ_IDLE;
                        end else begin
                            mShift_q <= mByte;
                            mosi_q <= mShift_q[6];
                            mCnt_q <= mCnt_q + 3'h1;
                        end
                    end
                end
                default: begin
                    state_q <= spq_pkg::SPQ_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Receive side and flags
    // ****************************************
    // Set beats a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rxFull_q <= 1'b0;
            ovf_q <= 1'b0;
            mode_fault_flag_q <= 1'b0;
            ovfArm_q <= 1'b0;
            modfArm_q <= 1'b0;
            rxData_q <= `SPQ_BYTE_ZERO;
            doneSeen_q <= 1'b0;
        end else if (!stopMode) begin
            doneSeen_q <= doneS2_q;
            if (rxEvt && (rxFull_q || ovf_q)) begin
                ovf_q <= 1'b1;
            end else if (dataRead && flagOk && ovfArm_q) begin
                ovf_q <= 1'b0;
            end
            if (rxEvt && !rxFull_q && !ovf_q) begin
                rxFull_q <= 1'b1;
                rxData_q <= rxByte;
            end else if (dataRead && flagOk) begin
                rxFull_q <= 1'b0;
            end
            if (statusRead && flagOk) begin
                ovfArm_q <= ovf_q;
            end else if (dataRead && flagOk) begin
                ovfArm_q <= 1'b0;
            end
            if (faultNow) begin
                mode_fault_flag_q <= 1'b1;
            end else if (ctlWrite && flagOk && modfArm_q) begin
                mode_fault_flag_q <= 1'b0;
            end
            if (statusRead && flagOk) begin
                modfArm_q <= mode_fault_flag_q;
            end else if (ctlWrite && flagOk) begin
                modfArm_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Pin drivers and requests
    // ****************************************
    // Registered so every output is a flop
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sckOut <= 1'b0;
            sckOe <= 1'b0;
            mosiOut <= 1'b1;
            mosiOe <= 1'b0;
            misoOe <= 1'b0;
            pinsOwned <= 1'b0;
            txIrq <= 1'b0;
            rxIrq <= 1'b0;
            slvRst_q <= 1'b1;
        end else begin
            slvRst_q <= !enable_q || master_q;
            pinsOwned <= enable_q;
            sckOut <= sck_q;
            sckOe <= enable_q && master_q;
            // Open drain drives only the low level
            mosiOut <= wiredOr_q ? 1'b0 : mosi_q;
            mosiOe <= enable_q && master_q && (!wiredOr_q || !mosi_q);
            misoOe <= enable_q && !master_q && !ssS2_q;
            txIrq <= txEmpty_q && txIe_q;
            rxIrq <= (rxFull_q && rxIe_q && enable_q)
                || (rxIe_q && error_irq_enable_q && (ovf_q || mode_fault_flag_q));
        end
    end

    // ****************************************
    // Slave domain on the link clock
    // ****************************************
    // Link clock stops between frames, so reset acts on its edges
    always_ff @(posedge linkClk) begin
        rstL1_q <= slvRst_q;
        rstL2_q <= rstL1_q;
        ldL1_q <= txTgl_q;
        ldL2_q <= ldL1_q;
    end

    assign sNext = {sShift_q[6:0], mosiIn};

    // Slave shifter; buffer word is stable while its toggle is pending
    always_ff @(posedge linkClk) begin
        if (rstL2_q) begin
            sShift_q <= `SPQ_BYTE_ZERO;
            sCnt_q <= `SPQ_CNT_ZERO;
            sHold_q <= `SPQ_BYTE_ZERO;
            miso_q <= 1'b0;
            ldSeen_q <= 1'b0;
            ackTgl_q <= 1'b0;
            doneTgl_q <= 1'b0;
        end else begin
            sCnt_q <= sCnt_q + 3'h1;
            if (sCnt_q == `SPQ_LAST_BIT) begin
                sHold_q <= sNext;
                doneTgl_q <= ~doneTgl_q;
                if (ldL2_q != ldSeen_q) begin
                    sShift_q <= txBuf_q;
                    miso_q <= txBuf_q[7];
                    ldSeen_q <= ldL2_q;
                    ackTgl_q <= ~ackTgl_q;
                end else begin
                    sShift_q <= sNext;
                    miso_q <= sNext[7];
                end
            end else begin
                sShift_q <= sNext;
                miso_q <= sNext[7];
            end
        end
    end

    assign misoOut = miso_q;
    assign rxData = rxData_q;
    assign txEmptyFlag = txEmpty_q;
    assign rxFullFlag = rxFull_q;
    assign overflowFlag = ovf_q;
    assign modeFaultFlag = mode_fault_flag_q;
    assign enableFlag = enable_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    tx_irq_level_a: assert property (!stopMode |=> txIrq == $past(txEmpty_q && txIe_q))
        else $error("tx irq does not follow flag");
    rx_irq_gate_a: assert property (!rxIe_q && !$past(rxIe_q) |-> !rxIrq)
        else $error("rx irq without rx enable");
    fault_clears_en_a: assert property (faultNow && !stopMode |=> !enable_q && mode_fault_flag_q)
        else $error("mode fault left module enabled");
    fault_gated_a: assert property (!faultEn_q && !mode_fault_flag_q && !ctlWrite |=> !mode_fault_flag_q)
        else $error("mode fault set while detection off");
    disable_empty_a: assert property (!enable_q && !stopMode |=> txEmpty_q)
        else $error("tx empty not set while disabled");
    overflow_keep_a: assert property (rxEvt && rxFull_q && !stopMode |=> ovf_q && $stable(rxData_q))
        else $error("overflow lost unread byte");
    break_freeze_a: assert property (breakActive && !breakClearEnable && !rxEvt && !stopMode
        |=> rxFull_q == $past(rxFull_q))
        else $error("rx flag changed in protected break");
    break_write_a: assert property (breakActive && !breakClearEnable && dataWrite && txEmpty_q
        && enable_q && !stopMode |=> txEmpty_q)
        else $error("break write was accepted");
    stop_hold_a: assert property (stopMode ##1 stopMode |-> $stable(txBuf_q) && $stable(state_q))
        else $error("state moved during stop");
    miso_drive_a: assert property (misoOe |-> $past(!master_q && !ssS2_q))
        else $error("slave out driven while not selected");
endmodule : spq_spi_core
`default_nettype wire

// ===== tb/spq_far_end.sv
`default_nettype none
// ****************************************
// Far-side serial device model
// ****************************************
module spq_far_end (
    // Lines to and from the design acting as master
    input wire logic sckIn,
    input wire logic mosiLine,
    output logic misoDrv,
    // Lines driven when this model is master
    output logic linkClk,
    output logic mosiDrv,
    output logic selN
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] txSh = 8'h00; // Byte returned to the master
    logic [7:0] rxSh = 8'h00; // Byte being collected
    int nBit = 0; // Bits of the current byte
    logic [7:0] got[$]; // Completed bytes from the master
    initial begin
        linkClk = 1'b0;
        mosiDrv = 1'b0;
        selN = 1'b1;
    end
    assign misoDrv = txSh[7];
    // Sample on the rising serial clock
    always @(posedge sckIn) begin
        rxSh = {rxSh[6:0], mosiLine};
        nBit++;
        if (nBit == 8) begin
            got.push_back(rxSh);
            nBit = 0;
        end
    end
    // Shift on the falling edge; fill changes so a stale bit never looks valid
    always @(negedge sckIn) txSh <= {txSh[6:0], ~txSh[7]};
    task load(input logic [7:0] b);
        txSh = b;
    endtask : load
    task sel(input logic v);
        selN = v;
    endtask : sel
    // Free clock edges, only used while the slave side is held in reset
    task tick(input int n);
        repeat (n) begin
            #15 linkClk = 1'b1;
            #15 linkClk = 1'b0;
        end
    endtask : tick
    // One framed byte, MSB first, clock parked low outside the frame
    task xfer(input logic [7:0] b);
        selN = 1'b0;
        #45;
        for (int i = 7; i >= 0; i--) begin
            mosiDrv = b[i];
            #7.5 linkClk = 1'b1;
            #15 linkClk = 1'b0;
            #7.5;
        end
        mosiDrv = ~b[0];
        #45 selN = 1'b1;
    endtask : xfer
endmodule : spq_far_end
`default_nettype wire

// ===== tb/testbench.sv
`default_nettype none
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin nMismatch++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
// ****************************************
// Self-checking bench
// ****************************************
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [8:0] cfg = 9'h000; // {en,mst,wor,tie,rie,eie,fde,rate}
    logic ctlWrite = 1'b0;
    logic [2:0] strb = 3'h0; // {write,read,status}
    logic [7:0] dIn = 8'h00;
    logic waitMode = 1'b0;
    logic breakActive = 1'b0;
    logic stopMode = 1'b0;
    logic bce = 1'b0; // Break clear enable
    logic [31:0] seed = 32'h0000_fbd5;
    int nMismatch = 0;
    int totalChecks = 0;
    int nSck = 0; // Serial clock rises seen
    int n0;
    time tRise, t1, t2;
    logic [7:0] a, pb, g;
    wire logic sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, pinsOwned;
    wire logic txEmptyFlag, rxFullFlag, overflowFlag, modeFaultFlag, enableFlag, txIrq, rxIrq;
    wire logic linkClk, mosiIn, misoIn, slaveSelN;
    wire logic [7:0] rxData;
    // Open-drain line with pull-up
    wire logic mosiLine = mosiOe ? mosiOut : 1'b1;
    always #4 sys_clk = ~sys_clk;
    always @(posedge sckOut) begin
        nSck++;
        tRise = $time;
    end
    spq_spi_core spq_spi_core_i (.sys_clk(sys_clk), .reset(reset), .linkClk(linkClk), .ctlWrite(ctlWrite),
        .enableIn(cfg[8]), .masterIn(cfg[7]), .wiredOrIn(cfg[6]), .txIrqEnIn(cfg[5]), .rxIrqEnIn(cfg[4]),
        .errIrqEnIn(cfg[3]), .faultDetEnIn(cfg[2]), .rateIn(cfg[1:0]), .dataWrite(strb[2]), .dataIn(dIn),
        .dataRead(strb[1]), .statusRead(strb[0]), .waitMode(waitMode), .stopMode(stopMode),
        .breakActive(breakActive), .breakClearEnable(bce), .mosiIn(mosiIn), .misoIn(misoIn),
        .slaveSelN(slaveSelN), .sckOut(sckOut), .sckOe(sckOe), .mosiOut(mosiOut), .mosiOe(mosiOe),
        .misoOut(misoOut), .misoOe(misoOe), .pinsOwned(pinsOwned), .rxData(rxData),
        .txEmptyFlag(txEmptyFlag), .rxFullFlag(rxFullFlag), .overflowFlag(overflowFlag),
        .modeFaultFlag(modeFaultFlag), .enableFlag(enableFlag), .txIrq(txIrq), .rxIrq(rxIrq));
    spq_far_end spq_far_end_i (.sckIn(sckOut), .mosiLine(mosiLine), .misoDrv(misoIn),
        .linkClk(linkClk), .mosiDrv(mosiIn), .selN(slaveSelN));
    // ****************************************
    // Helpers
    // ****************************************
    // Expected receive request from {rf,ov,mf,rie,eie,en}
    function automatic logic expRxIrq(input logic [5:0] v);
        return (v[2] & v[0] & v[5]) | (v[2] & v[1] & (v[4] | v[3]));
    endfunction : expRxIrq
    task automatic rnd(output logic [7:0] v);
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        v = seed[7:0];
    endtask : rnd
    // Let the edge's updates land before looking
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : cyc
    task automatic ctl(input logic [8:0] v);
        @(posedge sys_clk);
        cfg <= v;
        ctlWrite <= 1'b1;
        @(posedge sys_clk);
        ctlWrite <= 1'b0;
    endtask : ctl
    task automatic strobe(input logic [2:0] s, input logic [7:0] d);
        @(posedge sys_clk);
        strb <= s;
        dIn <= d;
        @(posedge sys_clk);
        strb <= 3'h0;
    endtask : strobe
    task automatic waitRx(input int lim);
        for (int k = 0; k < lim && rxFullFlag !== 1'b1; k++) cyc(1);
        `CHK(rxFullFlag, 1'b1)
    endtask : waitRx
    task automatic waitSck(input int target);
        for (int k = 0; k < 400 && nSck < target; k++) cyc(1);
    endtask : waitSck
    task automatic reportAndStop;
        $display("checks=%0d mismatches=%0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : reportAndStop
    // Hang guard, far beyond the slowest rate's traffic
    initial begin
        repeat (30000) @(posedge sys_clk);
        nMismatch++;
        reportAndStop();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        fork
            spq_far_end_i.tick(3);
        join_none
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        cyc(1);
        `CHK({txEmptyFlag, rxFullFlag, overflowFlag, modeFaultFlag, enableFlag, pinsOwned, txIrq, rxIrq}, 8'h80)
        // Random master bytes, every rate code, wired-or on odd passes
        for (int i = 0; i < 4; i++) begin
            ctl({2'b11, i[0], 4'b1100, i[1:0]});
            rnd(pb);
            rnd(a);
            spq_far_end_i.load(pb);
            cyc(2);
            `CHK(txIrq, 1'b1)
            `CHK(pinsOwned & sckOe, 1'b1)
            n0 = nSck;
            strobe(3'b100, a);
            cyc(12);
            `CHK(i[0] ? mosiOut : mosiOe, ~i[0])
            waitRx(3000);
            `CHK(rxData, pb)
            `CHK(nSck - n0, 8)
            g = spq_far_end_i.got.pop_front();
            `CHK(g, a)
            cyc(2);
            `CHK(rxIrq, expRxIrq(6'b100101))
            strobe(3'b010, 8'h00);
            cyc(2);
            `CHK({rxFullFlag, rxIrq}, 2'b00)
        end
        // Queued byte follows at once; second byte overflows
        ctl(9'b1_1011_0000);
        rnd(pb);
        rnd(a);
        spq_far_end_i.load(pb);
        n0 = nSck;
        strobe(3'b100, a);
        waitSck(n0 + 1);
        t1 = tRise;
        strobe(3'b100, ~a);
        cyc(3);
        `CHK(txEmptyFlag, 1'b0)
        waitRx(200);
        `CHK(rxData, pb)
        cyc(2);
        `CHK(txEmptyFlag, 1'b1)
        waitSck(n0 + 16);
        t2 = tRise;
        `CHK((t2 - t1) / 8, 120)
        cyc(40);
        `CHK({overflowFlag, rxData}, {1'b1, pb})
        g = spq_far_end_i.got.pop_front();
        `CHK(g, a)
        g = spq_far_end_i.got.pop_front();
        `CHK(g, ~a)
        strobe(3'b010, 8'h00);
        cyc(2);
        `CHK({rxFullFlag, overflowFlag, rxIrq}, {2'b01, expRxIrq(6'b010100)})
        ctl(9'b1_1011_1000);
        cyc(2);
        `CHK(rxIrq, expRxIrq(6'b010111))
        ctl(9'b1_1010_1000);
        cyc(2);
        `CHK(rxIrq, 1'b0)
        // Partial reset keeps flags and control bits
        ctl(9'b0_1011_1000);
        cyc(2);
        `CHK({txEmptyFlag, pinsOwned, enableFlag, overflowFlag}, 4'b1001)
        `CHK(rxIrq, expRxIrq(6'b010110))
        // Clearing is allowed in a break when clear enable is set
        @(posedge sys_clk);
        {breakActive, bce} <= 2'b11;
        strobe(3'b001, 8'h00);
        strobe(3'b010, 8'h00);
        cyc(2);
        @(posedge sys_clk);
        {breakActive, bce} <= 2'b00;
        `CHK({overflowFlag, rxIrq}, 2'b00)
        // Data writes dropped in wait mode and in protected break
        ctl(9'b1_1001_0000);
        for (int m = 0; m < 2; m++) begin
            @(posedge sys_clk);
            {waitMode, breakActive} <= m[0] ? 2'b01 : 2'b10;
            n0 = nSck;
            strobe(3'b100, 8'h5a);
            cyc(6);
            `CHK({txEmptyFlag, nSck - n0}, {1'b1, 32'h0000_0000})
            @(posedge sys_clk);
            {waitMode, breakActive} <= 2'b00;
        end
        // Stop mid-byte freezes the serial clock, resume finishes the byte
        strobe(3'b100, 8'hc3);
        cyc(6);
        @(posedge sys_clk);
        stopMode <= 1'b1;
        cyc(2);
        n0 = nSck;
        cyc(40);
        `CHK(nSck - n0, 0)
        @(posedge sys_clk);
        stopMode <= 1'b0;
        waitRx(400);
        g = spq_far_end_i.got.pop_front();
        `CHK(g, 8'hc3)
        strobe(3'b010, 8'h00);
        cyc(2);
        // Select low on a master: only with detection enabled
        ctl(9'b1_1001_1000);
        spq_far_end_i.sel(1'b0);
        cyc(8);
        `CHK({modeFaultFlag, enableFlag}, 2'b01)
        ctl(9'b1_1001_1100);
        cyc(8);
        `CHK({modeFaultFlag, enableFlag, pinsOwned, txEmptyFlag}, 4'b1001)
        `CHK(rxIrq, expRxIrq(6'b001110))
        spq_far_end_i.sel(1'b1);
        cyc(6);
        strobe(3'b001, 8'h00);
        ctl(9'b0_1001_1000);
        cyc(2);
        `CHK({modeFaultFlag, rxIrq}, 2'b00)
        // Slave byte from the far master
        ctl(9'b1_0001_0000);
        cyc(4);
        `CHK(misoOe, 1'b0)
        spq_far_end_i.tick(2);
        rnd(pb);
        fork
            spq_far_end_i.xfer(pb);
        join_none
        cyc(20);
        `CHK(misoOe, 1'b1)
        waitRx(400);
        `CHK(rxData, pb)
        cyc(10);
        `CHK(misoOe, 1'b0)
        reportAndStop();
    end
endmodule : testbench
`undef CHK
`default_nettype wire
